// ---- logic/ssl_core.sv ----
// Status, indication and safety output logic of a contactless safety sensor.
// Assumes pins asynchronous to pclk, APB master on pclk, power-on drives presetn.
`timescale 1ns/100ps
module ssl_core #(
  parameter longint unsigned BLINK_HALF = ssl_pkg::BLINK_HALF_CYC,
  parameter longint unsigned FLASH_HALF = ssl_pkg::FLASH_HALF_CYC,
  parameter longint unsigned WARN_LIM   = ssl_pkg::WARN_CYC,
  parameter longint unsigned PROT_LIM   = ssl_pkg::PROTECT_CYC
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Sensor pins
  input  wire ssl_pkg::ssl_pins_t pins,
  // Safety and diagnostic outputs
  output logic                   safety_output_a,
  output logic                   safety_output_b,
  output logic                   diag_out,
  // Indicators and interrupt
  output logic                   led_green,
  output logic                   led_red,
  output logic                   led_yellow,
  output logic                   irq
);
  localparam logic [31:0] BLINK_TOP = 32'(BLINK_HALF - 1);
  localparam logic [31:0] FLASH_TOP = 32'(FLASH_HALF - 1);
  localparam logic [ssl_pkg::CNT_W-1:0] WARN_TOP = ssl_pkg::CNT_W'(WARN_LIM - 1);
  localparam logic [ssl_pkg::CNT_W-1:0] PROT_TOP = ssl_pkg::CNT_W'(PROT_LIM - 1);

  ssl_pkg::ssl_state_t st;
  ssl_pkg::ssl_state_t next_st;
  ssl_pkg::ssl_pins_t  ps;

  logic       in_ok;
  logic       warn;
  logic       crit;
  logic [2:0] wcode;
  logic       timeout;
  logic       enable;
  logic       setup;
  logic       access;
  logic [2:0] code;
  logic       red_flash;
  logic [4:0] seq_len;

  // Pins cross into pclk before anything looks at them
  ssl_sync #(
    .WIDTH($bits(ssl_pkg::ssl_pins_t))
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .din   (pins),
    .dout  (ps)
  );

  assign in_ok   = ps.safety_input_a & ps.safety_input_b;
  assign warn    = ps.fault_out_a | ps.fault_out_b | ps.fault_cross | ps.fault_temp;
  assign crit    = ps.fault_internal | ps.fault_actuator;
  assign timeout = warn & (st.warn_cnt == WARN_TOP);
  assign setup   = psel & ~penable;
  assign access  = psel & penable & st.pready;
  // Outputs follow the synchronised actuator level with no filtering delay
  assign enable  = ps.actuator & in_ok & ~st.err & ~crit & ~timeout
                   & ~st.teach & ~st.protect;

  always_comb begin
    if (ps.fault_out_a) begin
      wcode = ssl_pkg::CODE_OUT_A;
    end else if (ps.fault_out_b) begin
      wcode = ssl_pkg::CODE_OUT_B;
    end else if (ps.fault_cross) begin
      wcode = ssl_pkg::CODE_CROSS;
    end else if (ps.fault_temp) begin
      wcode = ssl_pkg::CODE_TEMP;
    end else begin
      wcode = ssl_pkg::CODE_NONE;
    end
  end

  assign code      = st.err ? st.err_code : wcode;
  assign seq_len   = 5'({code, 1'b0}) + ssl_pkg::FLASH_PAUSE_STEPS;
  // Pulse group, then a dark pause that is longer than one pulse gap
  assign red_flash = (st.flash_step < 5'({code, 1'b0})) & ~st.flash_step[0];

  always_comb begin
    logic [ssl_pkg::IRQ_W-1:0] ev;
    logic [ssl_pkg::IRQ_W-1:0] clr;
    logic                      start;
    ev      = '0;
    clr     = '0;
    start   = 1'b0;
    next_st = st;

    // 1 Hz blink base
    if (st.blink_cnt == BLINK_TOP) begin
      next_st.blink_cnt = '0;
      next_st.blink     = ~st.blink;
    end else begin
      next_st.blink_cnt = st.blink_cnt + 32'h1;
    end
    // Flash code sequencer
    if (st.flash_cnt == FLASH_TOP) begin
      next_st.flash_cnt = '0;
      if (st.flash_step >= seq_len - 5'h1) begin
        next_st.flash_step = '0;
      end else begin
        next_st.flash_step = st.flash_step + 5'h1;
      end
    end else begin
      next_st.flash_cnt = st.flash_cnt + 32'h1;
    end

    // Warning timer restarts whenever the warning drops
    if (!warn) begin
      next_st.warn_cnt = '0;
    end else if (st.warn_cnt != WARN_TOP) begin
      next_st.warn_cnt = st.warn_cnt + 1'b1;
    end
    next_st.prev_warn = warn;
    ev[ssl_pkg::IRQ_WARN_BIT] = warn & ~st.prev_warn;

    // Error latch
    if (!st.err) begin
      if (crit || timeout) begin
        next_st.err       = 1'b1;
        next_st.open_seen = 1'b0;
        next_st.err_code  = ps.fault_actuator ? ssl_pkg::CODE_ACT :
                            (ps.fault_internal ? ssl_pkg::CODE_NONE : wcode);
        ev[ssl_pkg::IRQ_ERR_BIT] = 1'b1;
      end
    end else if (!crit && !warn) begin
      if (!ps.actuator) begin
        next_st.open_seen = 1'b1;
      end else if (st.open_seen) begin
        next_st.err = 1'b0;
      end
    end

    // Resume a protection interval lost to power failure, once pins settled
    if (st.boot != 2'h3) begin
      next_st.boot = st.boot + 2'h1;
    end
    if (st.boot == 2'h2 && ps.protect_resume) begin
      start = 1'b1;
    end

    // APB: registered answer, no wait state on any access
    next_st.pready = setup;
    if (setup) begin
      next_st.pslverr = 1'b0;
      next_st.prdata  = '0;
      case (paddr)
        ssl_pkg::OFF_CTRL: begin
          next_st.prdata[ssl_pkg::CTRL_TEACH_BIT] = st.teach;
        end
        ssl_pkg::OFF_STATUS: begin
          next_st.prdata[ssl_pkg::ST_EN_BIT]    = st.so_a;
          next_st.prdata[ssl_pkg::ST_ACT_BIT]   = ps.actuator;
          next_st.prdata[ssl_pkg::ST_INOK_BIT]  = in_ok;
          next_st.prdata[ssl_pkg::ST_MARG_BIT]  = ps.marginal;
          next_st.prdata[ssl_pkg::ST_WARN_BIT]  = warn;
          next_st.prdata[ssl_pkg::ST_ERR_BIT]   = st.err;
          next_st.prdata[ssl_pkg::ST_TEACH_BIT] = st.teach;
          next_st.prdata[ssl_pkg::ST_PROT_BIT]  = st.protect;
          next_st.prdata[ssl_pkg::ST_CODE_LSB +: 3] = code;
        end
        ssl_pkg::OFF_IRQ_STAT: begin
          next_st.prdata[ssl_pkg::IRQ_W-1:0] = st.irq_stat;
        end
        ssl_pkg::OFF_IRQ_MASK: begin
          next_st.prdata[ssl_pkg::IRQ_W-1:0] = st.irq_mask;
        end
        default: begin
          next_st.pslverr = 1'b1;
        end
      endcase
    end
    if (access && pwrite) begin
      if (paddr == ssl_pkg::OFF_CTRL) begin
        next_st.teach = pwdata[ssl_pkg::CTRL_TEACH_BIT];
        start = start | pwdata[ssl_pkg::CTRL_PROT_BIT];
      end
      if (paddr == ssl_pkg::OFF_IRQ_MASK) begin
        next_st.irq_mask = pwdata[ssl_pkg::IRQ_W-1:0];
      end
    end
    // Only bits that were actually returned are cleared by the read
    if (access && !pwrite && paddr == ssl_pkg::OFF_IRQ_STAT) begin
      clr = st.prdata[ssl_pkg::IRQ_W-1:0];
    end

    // Protection interval ends once expired and an actuator is seen
    if (start) begin
      next_st.protect     = 1'b1;
      next_st.protect_cnt = '0;
    end else if (st.protect) begin
      if (st.protect_cnt != PROT_TOP) begin
        next_st.protect_cnt = st.protect_cnt + 1'b1;
      end else if (ps.actuator) begin
        next_st.protect = 1'b0;
        ev[ssl_pkg::IRQ_PROT_BIT] = 1'b1;
      end
    end

    // Safety outputs
    next_st.so_a = enable;
    next_st.so_b = enable;
    ev[ssl_pkg::IRQ_DROP_BIT] = st.so_a & ~enable;

    // Diagnostic output: low on any fault, teach or protection
    if (st.teach || st.protect || st.err || crit || warn || !ps.actuator) begin
      next_st.diag = 1'b0;
    end else begin
      next_st.diag = ps.marginal ? st.blink : 1'b1;
    end

    // Indicators, highest priority first
    if (st.teach) begin
      next_st.led_g = 1'b0;
      next_st.led_r = 1'b1;
      next_st.led_y = st.blink;
    end else if (st.err || crit) begin
      next_st.led_g = 1'b0;
      next_st.led_r = (code == ssl_pkg::CODE_NONE) ? st.blink : red_flash;
      next_st.led_y = 1'b0;
    end else if (warn) begin
      next_st.led_g = 1'b0;
      next_st.led_r = red_flash;
      next_st.led_y = 1'b0;
    end else if (st.protect) begin
      next_st.led_g = st.blink;
      next_st.led_r = 1'b0;
      next_st.led_y = 1'b0;
    end else if (!in_ok) begin
      next_st.led_g = st.blink;
      next_st.led_r = 1'b0;
      next_st.led_y = ps.actuator;
    end else if (ps.actuator) begin
      next_st.led_g = 1'b0;
      next_st.led_r = 1'b0;
      next_st.led_y = ps.marginal ? st.blink : 1'b1;
    end else begin
      next_st.led_g = 1'b1;
      next_st.led_r = 1'b0;
      next_st.led_y = 1'b0;
    end

    // Sticky events: a new event wins over the read clear
    next_st.irq_stat = (st.irq_stat & ~clr) | ev;
    next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st          <= '0;
      st.irq_mask <= ssl_pkg::IRQ_MASK_RST;
    end else begin
      st <= next_st;
    end
  end

  assign prdata          = st.prdata;
  assign pready          = st.pready;
  assign pslverr         = st.pslverr;
  assign safety_output_a = st.so_a;
  assign safety_output_b = st.so_b;
  assign diag_out        = st.diag;
  assign led_green       = st.led_g;
  assign led_red         = st.led_r;
  assign led_yellow      = st.led_y;
  assign irq             = st.irq;

  // Checks
  logic idle;
  assign idle = ~st.teach & ~st.err & ~crit & ~warn & ~st.protect;

  property p_drop;
    @(posedge pclk) disable iff (!presetn)
      !ps.actuator |=> !safety_output_a && !safety_output_b;
  endproperty
  a_drop: assert property (p_drop) else $error("outputs stayed on without actuator");

  property p_ready;
    @(posedge pclk) disable iff (!presetn)
      idle && in_ok && !ps.actuator |=> led_green && !led_red && !led_yellow
      && !diag_out && !safety_output_a;
  endproperty
  a_ready: assert property (p_ready) else $error("ready indication wrong");

  property p_noinput;
    @(posedge pclk) disable iff (!presetn)
      idle && !in_ok |=> led_green == $past(st.blink) && !safety_output_b
      && led_yellow == $past(ps.actuator);
  endproperty
  a_noinput: assert property (p_noinput) else $error("missing input indication wrong");

  property p_act;
    @(posedge pclk) disable iff (!presetn)
      idle && in_ok && ps.actuator && !ps.marginal |=> led_yellow && !led_green
      && safety_output_a && safety_output_b && diag_out;
  endproperty
  a_act: assert property (p_act) else $error("actuated state wrong");

  property p_marg;
    @(posedge pclk) disable iff (!presetn)
      idle && in_ok && ps.actuator && ps.marginal |=> safety_output_a
      && led_yellow == $past(st.blink) && diag_out == $past(st.blink);
  endproperty
  a_marg: assert property (p_marg) else $error("marginal state wrong");

  property p_teach;
    @(posedge pclk) disable iff (!presetn)
      st.teach |=> led_red && !safety_output_a && !diag_out && !led_green;
  endproperty
  a_teach: assert property (p_teach) else $error("teach indication wrong");

  property p_internal;
    @(posedge pclk) disable iff (!presetn)
      ps.fault_internal |=> !safety_output_a && !safety_output_b && !diag_out;
  endproperty
  a_internal: assert property (p_internal) else $error("internal error kept outputs");

  property p_clear;
    @(posedge pclk) disable iff (!presetn)
      $fell(st.err) |-> $past(st.open_seen) && $past(ps.actuator) && !$past(warn);
  endproperty
  a_clear: assert property (p_clear) else $error("error cleared without guard cycle");

  property p_warn;
    @(posedge pclk) disable iff (!presetn)
      warn && !st.err && !crit && !timeout && !st.teach && !st.protect
      && in_ok && ps.actuator |=> !diag_out && safety_output_a;
  endproperty
  a_warn: assert property (p_warn) else $error("warning state wrong");

  property p_timeout;
    @(posedge pclk) disable iff (!presetn)
      timeout |=> st.err && !safety_output_a;
  endproperty
  a_timeout: assert property (p_timeout) else $error("warning did not escalate");

  property p_protect;
    @(posedge pclk) disable iff (!presetn)
      !st.teach && !st.err && !crit && !warn && st.protect
      |=> led_green == $past(st.blink) && !led_red && !led_yellow
      && !safety_output_a && !diag_out;
  endproperty
  a_protect: assert property (p_protect) else $error("protection indication wrong");

  c_teach:   cover property (@(posedge pclk) disable iff (!presetn) $rose(st.teach));
  c_clear:   cover property (@(posedge pclk) disable iff (!presetn) $fell(st.err));
  c_marg:    cover property (@(posedge pclk) disable iff (!presetn) diag_out && ps.marginal);
  c_protect: cover property (@(posedge pclk) disable iff (!presetn) $fell(st.protect));
endmodule

// ---- logic/ssl_pkg.sv ----
// Constants, field layout and state types of the safety sensor status logic.
// Assumes a 50 MHz pclk and APB register access with 8-bit byte addresses.
package ssl_pkg;
  localparam int CLK_HZ      = 50_000_000;
  localparam int BLINK_HZ    = 1;
  localparam int FLASH_MS    = 250;
  localparam int WARN_MIN    = 30;
  localparam int PROTECT_MIN = 10;
  localparam int CNT_W       = 40;
  localparam longint unsigned BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
  localparam longint unsigned FLASH_HALF_CYC = (CLK_HZ / 1000) * FLASH_MS;
  localparam longint unsigned WARN_CYC       = longint'(WARN_MIN) * 60 * CLK_HZ;
  localparam longint unsigned PROTECT_CYC    = longint'(PROTECT_MIN) * 60 * CLK_HZ;
  localparam logic [4:0] FLASH_PAUSE_STEPS   = 5'h06;
  // Register offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
  // Control fields
  localparam int CTRL_TEACH_BIT = 0;
  localparam int CTRL_PROT_BIT  = 1;
  // Status fields
  localparam int ST_EN_BIT    = 0;
  localparam int ST_ACT_BIT   = 1;
  localparam int ST_INOK_BIT  = 4;
  localparam int ST_MARG_BIT  = 5;
  localparam int ST_WARN_BIT  = 6;
  localparam int ST_ERR_BIT   = 7;
  localparam int ST_TEACH_BIT = 8;
  localparam int ST_PROT_BIT  = 9;
  localparam int ST_CODE_LSB  = 10;
  // Interrupt events
  localparam int IRQ_W        = 4;
  localparam int IRQ_DROP_BIT = 0;
  localparam int IRQ_WARN_BIT = 1;
  localparam int IRQ_ERR_BIT  = 2;
  localparam int IRQ_PROT_BIT = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
  // Flash codes
  localparam logic [2:0] CODE_NONE  = 3'h0;
  localparam logic [2:0] CODE_OUT_A = 3'h1;
  localparam logic [2:0] CODE_OUT_B = 3'h2;
  localparam logic [2:0] CODE_CROSS = 3'h3;
  localparam logic [2:0] CODE_TEMP  = 3'h4;
  localparam logic [2:0] CODE_ACT   = 3'h5;

  typedef struct packed {
    logic actuator;
    logic marginal;
    logic safety_input_a;
    logic safety_input_b;
    logic fault_out_a;
    logic fault_out_b;
    logic fault_cross;
    logic fault_temp;
    logic fault_actuator;
    logic fault_internal;
    logic protect_resume;
  } ssl_pins_t;

  typedef struct packed {
    logic             teach;
    logic             protect;
    logic [CNT_W-1:0] protect_cnt;
    logic [CNT_W-1:0] warn_cnt;
    logic             err;
    logic [2:0]       err_code;
    logic             open_seen;
    logic             blink;
    logic [31:0]      blink_cnt;
    logic [31:0]      flash_cnt;
    logic [4:0]       flash_step;
    logic [1:0]       boot;
    logic             prev_warn;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic             so_a;
    logic             so_b;
    logic             diag;
    logic             led_g;
    logic             led_r;
    logic             led_y;
    logic             irq;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } ssl_state_t;
endpackage

// ---- logic/ssl_sync.sv ----
// Two-flop synchroniser for a bundle of asynchronous pin levels.
// Assumes each bit is an independent level; no bus coherence is given.
`timescale 1ns/100ps
module ssl_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Levels
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// ---- verification/ssl_core_tb_top.sv ----
// Self-checking bench of the sensor status core over APB and field pins.
// Assumes shortened blink, flash, warning and protection counts.
`timescale 1ns/100ps
module ssl_core_tb_top;
  localparam int BH = 4;
  localparam int FH = 3;
  localparam int WL = 120;
  localparam int PL = 40;
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h00000000;
  logic [31:0]        prdata, rd;
  logic               pready, pslverr, perr, so_a, so_b, diag, g, r, y, irq, split;
  ssl_pkg::ssl_pins_t want = '0;
  ssl_pkg::ssl_pins_t pw;
  ssl_pkg::ssl_pins_t pins;
  int                 mismatches = 0, comparisons = 0, cyc = 0, r_up, y_up, g_up, d_up;

  always #10 pclk = ~pclk;

  ssl_core #(.BLINK_HALF(BH), .FLASH_HALF(FH), .WARN_LIM(WL), .PROT_LIM(PL)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins(pins), .safety_output_a(so_a), .safety_output_b(so_b), .diag_out(diag),
    .led_green(g), .led_red(r), .led_yellow(y), .irq(irq));

  ssl_field i_field (.pclk(pclk), .want(want), .pins(pins), .so_a(so_a), .so_b(so_b),
    .split(split));

  task automatic final_report();
    if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Generous ceiling; the whole sequence needs about 800 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Outputs as one vector: so_a so_b diag green red yellow
  function automatic logic [31:0] ov(input logic [5:0] m);
    return 32'({so_a, so_b, diag, g, r, y} & m);
  endfunction

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let the answering edge settle before anyone looks at outputs
    #1;
  endtask

  // Field levels; code 1..5 flash faults, 6 internal, 7 input b missing
  function automatic ssl_pkg::ssl_pins_t pv(input logic act, input logic [2:0] f);
    ssl_pkg::ssl_pins_t p;
    p = '0;
    p.actuator = act;
    p.safety_input_a = 1'b1;
    p.safety_input_b = (f != 3'h7);
    p.fault_out_a = (f == 3'h1);
    p.fault_out_b = (f == 3'h2);
    p.fault_cross = (f == 3'h3);
    p.fault_temp = (f == 3'h4);
    p.fault_actuator = (f == 3'h5);
    p.fault_internal = (f == 3'h6);
    return p;
  endfunction

  task automatic pin(input ssl_pkg::ssl_pins_t p);
    @(posedge pclk);
    want <= p;
    repeat (6) @(posedge pclk);
    #1;
  endtask

  // Counts rising edges of the indicators and the diagnostic output
  task automatic run(input int n);
    logic pr, py, pg, pd;
    r_up = 0; y_up = 0; g_up = 0; d_up = 0;
    pr = r; py = y; pg = g; pd = diag;
    repeat (n) begin
      @(posedge pclk);
      #1;
      r_up += int'(r & ~pr); y_up += int'(y & ~py);
      g_up += int'(g & ~pg); d_up += int'(diag & ~pd);
      pr = r; py = y; pg = g; pd = diag;
    end
  endtask

  // Guard open then close clears a latched error
  task automatic guard();
    pin(pv(1'b0, 3'h0));
    pin(pv(1'b1, 3'h0));
  endtask

  initial begin
    want <= pv(1'b0, 3'h0);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    #1;
    chk(ov(6'h3F), 32'h04);
    apb(1'b0, ssl_pkg::OFF_IRQ_MASK, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, ssl_pkg::OFF_STATUS, 32'h0);
    chk(rd, 32'h10);
    apb(1'b0, 8'h10, 32'h0);
    chk(32'(perr), 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, ssl_pkg::OFF_IRQ_MASK, 32'h1);
    pin(pv(1'b1, 3'h0));
    chk(ov(6'h3F), 32'h39);
    pin(pv(1'b0, 3'h0));
    chk(ov(6'h3F), 32'h04);
    chk(32'(irq), 32'h1);
    apb(1'b1, ssl_pkg::OFF_IRQ_MASK, 32'h0);
    chk(32'(irq), 32'h0);
    apb(1'b1, ssl_pkg::OFF_IRQ_MASK, 32'h1);
    chk(32'(irq), 32'h1);
    apb(1'b0, ssl_pkg::OFF_IRQ_STAT, 32'h0);
    chk(rd & 32'h1, 32'h1);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0);
    pw = pv(1'b1, 3'h0);
    pw.marginal = 1'b1;
    pin(pw);
    run(20);
    chk(ov(6'h36), 32'h30);
    chk(32'(y_up > 0 && d_up > 0), 32'h1);
    pin(pv(1'b0, 3'h7));
    run(20);
    chk(ov(6'h3B), 32'h00);
    chk(32'(g_up > 0), 32'h1);
    pin(pv(1'b1, 3'h7));
    run(20);
    chk(ov(6'h3B), 32'h09);
    chk(32'(g_up > 0), 32'h1);
    pin(pv(1'b1, 3'h0));
    for (int n = 1; n <= 5; n++) begin
      pin(pv(1'b1, 3'(n)));
      chk(ov(6'h3C), (n == 5) ? 32'h00 : 32'h30);
      apb(1'b0, ssl_pkg::OFF_STATUS, 32'h0);
      chk(32'(rd[12:10]), 32'(n));
      run((2 * n + 6) * FH);
      chk(32'(r_up), 32'(n));
      pin(pv(1'b1, 3'h0));
      if (n == 5) guard();
      chk(ov(6'h3F), 32'h39);
    end
    pin(pv(1'b1, 3'h6));
    run(20);
    chk(ov(6'h3C), 32'h00);
    chk(32'(r_up > 0), 32'h1);
    pin(pv(1'b1, 3'h0));
    chk(ov(6'h30), 32'h00);
    guard();
    chk(ov(6'h3F), 32'h39);
    pin(pv(1'b1, 3'h4));
    repeat (WL) @(posedge pclk);
    // A full code 4 period, so the long dark pause cannot hide every pulse
    run(50);
    chk(ov(6'h30), 32'h00);
    chk(32'(r_up > 0), 32'h1);
    pin(pv(1'b1, 3'h0));
    guard();
    apb(1'b1, ssl_pkg::OFF_CTRL, 32'h1);
    run(2);
    run(20);
    chk(ov(6'h3E), 32'h02);
    chk(32'(y_up > 0 && r_up == 0), 32'h1);
    apb(1'b1, ssl_pkg::OFF_CTRL, 32'h0);
    apb(1'b1, ssl_pkg::OFF_CTRL, 32'h2);
    run(20);
    chk(ov(6'h3A), 32'h00);
    chk(32'(g_up > 0), 32'h1);
    repeat (PL) @(posedge pclk);
    run(10);
    chk(ov(6'h30), 32'h30);
    pw = pv(1'b1, 3'h0);
    pw.protect_resume = 1'b1;
    want <= pw;
    repeat (4) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, ssl_pkg::OFF_STATUS, 32'h0);
    chk(32'(rd[9]), 32'h1);
    chk(32'(split), 32'h0);
    final_report();
  end
endmodule

// ---- verification/ssl_field.sv ----
// Far side model: sensor field levels and the safety monitoring module.
// Assumes the bench sets the wanted pin levels and reads the split flag.
`timescale 1ns/100ps
module ssl_field (
  // Clock
  input  wire logic               pclk,
  // Levels wanted by the bench
  input  wire ssl_pkg::ssl_pins_t want,
  // Field pins
  output ssl_pkg::ssl_pins_t      pins,
  // Safety channels seen by the monitor
  input  wire logic               so_a,
  input  wire logic               so_b,
  output logic                    split
);
  logic prev_diff;
  initial begin
    pins = '0;
    split = 1'b0;
    prev_diff = 1'b0;
  end
  // Field levels move on an edge; the core synchronises them anyway
  always @(posedge pclk) begin
    pins <= want;
  end
  // Monitor trips when the channels disagree two cycles running
  always @(posedge pclk) begin
    prev_diff <= so_a ^ so_b;
    if (prev_diff && (so_a ^ so_b)) begin
      split <= 1'b1;
    end
  end
endmodule
